/* bench/bsr_monitor.sv */
`timescale 1ns/1ps
module bsr_monitor (
  input logic                       clk_sys,
  input logic                       rst_n,
  input logic                       power_fail,
  input logic [bsr_pkg::ADDR_W-1:0] location_select,
  input logic                       select_low_n,
  input logic                       select_high,
  input logic                       gate_n,
  input logic                       strobe_n,
  input logic                       byte_lanes_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  addr_hold_a : assert property (!strobe_n && $past(!strobe_n) |-> $stable(location_select))
    else $error("address moved inside a write");
  recover_gap_a : assert property ($rose(select_low_n) |=> select_low_n && !select_high)
    else $error("no idle cycle between accesses");
  gate_write_a : assert property (!strobe_n |-> gate_n)
    else $error("output gate low while writing");
  no_fight_a : assert property (!gate_n |-> byte_lanes_oe_n)
    else $error("host drives lanes while gate low");
  fail_desel_a : assert property (power_fail && $past(power_fail) |-> select_low_n && !select_high)
    else $error("selected during power fail");
endmodule
bind bsr_host bsr_monitor u_bsr_monitor (.clk_sys, .rst_n, .power_fail, .location_select,
  .select_low_n, .select_high, .gate_n, .strobe_n, .byte_lanes_oe_n);

/* bench/bsr_sram_model.sv */
`timescale 1ns/1ps
module bsr_sram_model #(
  parameter int T_REC_NS   = 500,
  parameter int T_DESEL_NS = 20000
) (
  input  logic                       vcc_ok,
  input  logic [bsr_pkg::ADDR_W-1:0] location_select,
  input  logic                       select_low_n,
  input  logic                       select_high,
  input  logic                       gate_n,
  input  logic                       strobe_n,
  input  logic [bsr_pkg::DATA_W-1:0] byte_lanes_o,
  input  logic                       byte_lanes_oe_n,
  output logic [bsr_pkg::DATA_W-1:0] byte_lanes_i,
  output logic                       fail_int_n_i
);
  logic [7:0] mem [8192];
  logic       alive = 1'b1;
  logic       ok    = 1'b0;
  logic       drv;
  logic       wr_act;
  initial foreach (mem[i]) mem[i] = 8'hA5;
  // Pull-up resolved here; low only while supply is bad
  assign fail_int_n_i = vcc_ok;
  always @(negedge vcc_ok) alive <= #(T_DESEL_NS) 1'b0;
  always @(posedge vcc_ok) alive <= #(T_REC_NS) 1'b1;
  assign wr_act = alive && !strobe_n && !select_low_n && select_high;
  // Loss of supply ends the write without a capture
  always @(negedge wr_act) if (alive) mem[location_select] = byte_lanes_i;
  always @(location_select or select_low_n or select_high) begin
    ok = 1'b0;
    ok <= #(bsr_pkg::T_ACCESS_NS) 1'b1;
  end
  assign drv = alive && !select_low_n && select_high && !gate_n && strobe_n;
  // Floating or unsettled lanes show inverted data, never a lucky match
  assign byte_lanes_i = !byte_lanes_oe_n ? byte_lanes_o : (drv && ok) ? mem[location_select] : ~mem[location_select];
endmodule

/* bench/tb_bsr_host.sv */
`timescale 1ns/1ps
module tb_bsr_host;
  logic        clk_sys = 1'b0, rst_n = 1'b0, vcc_ok = 1'b1;
  logic        req_valid = 1'b0, req_write = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic [7:0]  req_wdata = 8'h00;
  logic        req_ready, rsp_valid, power_fail, select_low_n, select_high, gate_n, strobe_n;
  logic        byte_lanes_oe_n, fail_int_n_i;
  logic [7:0]  rsp_rdata, byte_lanes_o, byte_lanes_i;
  logic [12:0] location_select;
  int          n_errors = 0, cmp_count = 0;
  bsr_host u_bsr_host (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .req_valid       (req_valid),
    .req_write       (req_write),
    .req_addr        (req_addr),
    .req_wdata       (req_wdata),
    .req_ready       (req_ready),
    .rsp_valid       (rsp_valid),
    .rsp_rdata       (rsp_rdata),
    .power_fail      (power_fail),
    .power_good      (vcc_ok),
    .location_select (location_select),
    .select_low_n    (select_low_n),
    .select_high     (select_high),
    .gate_n          (gate_n),
    .strobe_n        (strobe_n),
    .byte_lanes_i    (byte_lanes_i),
    .byte_lanes_o    (byte_lanes_o),
    .byte_lanes_oe_n (byte_lanes_oe_n),
    .fail_int_n_i    (fail_int_n_i)
  );
  bsr_sram_model #(.T_REC_NS(500), .T_DESEL_NS(20000)) u_bsr_sram_model (
    .vcc_ok          (vcc_ok),
    .location_select (location_select),
    .select_low_n    (select_low_n),
    .select_high     (select_high),
    .gate_n          (gate_n),
    .strobe_n        (strobe_n),
    .byte_lanes_o    (byte_lanes_o),
    .byte_lanes_oe_n (byte_lanes_oe_n),
    .byte_lanes_i    (byte_lanes_i),
    .fail_int_n_i    (fail_int_n_i)
  );
  initial forever #50 clk_sys = ~clk_sys;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Entered and left just after a rising edge
  task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 500) begin @(posedge clk_sys); #1 n++; end
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) begin @(posedge clk_sys); #1; end
    check({7'h00, rsp_valid}, 8'h01);
  endtask
  task automatic sc_rdwr;
    xfer(1'b1, 13'h1FFF, 8'h3C);
    xfer(1'b1, 13'h0000, 8'hC3);
    xfer(1'b0, 13'h1FFF, 8'h00);
    check(rsp_rdata, 8'h3C);
    xfer(1'b0, 13'h0000, 8'h00);
    check(rsp_rdata, 8'hC3);
  endtask
  task automatic sc_pfail;
    vcc_ok = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 check({7'h00, power_fail}, 8'h01);
    check({7'h00, select_low_n}, 8'h01);
    check({7'h00, select_high}, 8'h00);
    repeat (500) @(posedge clk_sys);
    #1 vcc_ok = 1'b1;
    xfer(1'b0, 13'h1FFF, 8'h00);
    check(rsp_rdata, 8'h3C);
    check({7'h00, power_fail}, 8'h00);
    xfer(1'b1, 13'h0001, 8'h5A);
    xfer(1'b0, 13'h0001, 8'h00);
    check(rsp_rdata, 8'h5A);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    sc_rdwr();
    sc_pfail();
    final_report();
  end
  initial begin
    #(3000 * 100);
    n_errors++;
    final_report();
  end
endmodule

/* design/bsr_host.sv */
`timescale 1ns/1ps
module bsr_host (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire logic [bsr_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [bsr_pkg::DATA_W-1:0] req_wdata,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic [bsr_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                            power_fail,
  input  wire logic                       power_good,
  output logic [bsr_pkg::ADDR_W-1:0]      location_select,
  output logic                            select_low_n,
  output logic                            select_high,
  output logic                            gate_n,
  output logic                            strobe_n,
  input  wire logic [bsr_pkg::DATA_W-1:0] byte_lanes_i,
  output logic [bsr_pkg::DATA_W-1:0]      byte_lanes_o,
  output logic                            byte_lanes_oe_n,
  input  wire logic                       fail_int_n_i
);
  typedef struct packed {
    bsr_pkg::bsr_state_t          st;
    logic [bsr_pkg::CNT_W-1:0]    cnt;
    logic [bsr_pkg::ADDR_W-1:0]   addr;
    logic [bsr_pkg::DATA_W-1:0]   wdata;
    logic [bsr_pkg::DATA_W-1:0]   rdata;
    logic                         sel_n;
    logic                         sel_h;
    logic                         gate_n;
    logic                         strobe_n;
    logic                         oe_n;
    logic                         ready;
    logic                         rsp;
    logic                         fail;
  } bsr_regs_t;

  bsr_regs_t                  s_ff;
  bsr_regs_t                  nxt_s;
  logic                       fail_now;
  logic                       int_q;
  logic                       pg_q;
  logic [bsr_pkg::DATA_W-1:0] lanes_q;

  // Pin levels from outside the clock domain pass two flops first
  bsr_sync2 #(
    .W (1)
  ) u_bsr_sync2_int (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .raw     (fail_int_n_i),
    .synced  (int_q)
  );

  bsr_sync2 #(
    .W (1)
  ) u_bsr_sync2_pg (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .raw     (power_good),
    .synced  (pg_q)
  );

  bsr_sync2 #(
    .W (bsr_pkg::DATA_W)
  ) u_bsr_sync2_lanes (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .raw     (byte_lanes_i),
    .synced  (lanes_q)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rsp      = 1'b0;
    // Low interrupt means device deselect is imminent; stop at once
    fail_now = !int_q || !pg_q;
    if (s_ff.cnt != bsr_pkg::CNT_ZERO) begin
      nxt_s.cnt = s_ff.cnt - bsr_pkg::CNT_ONE;
    end
    if (fail_now && s_ff.st != bsr_pkg::BSR_FAILED) begin
      // Abort: a write cut here may only hurt this byte
      nxt_s.st       = bsr_pkg::BSR_FAILED;
      nxt_s.sel_n    = 1'b1;
      nxt_s.sel_h    = 1'b0;
      nxt_s.strobe_n = 1'b1;
      nxt_s.gate_n   = 1'b1;
      nxt_s.oe_n     = 1'b1;
      nxt_s.ready    = 1'b0;
      nxt_s.fail     = 1'b1;
    end else begin
      unique case (s_ff.st)
        bsr_pkg::BSR_IDLE: begin
          if (req_valid && s_ff.ready) begin
            nxt_s.ready = 1'b0;
            nxt_s.addr  = req_addr;
            nxt_s.wdata = req_wdata;
            nxt_s.sel_n = 1'b0;
            nxt_s.sel_h = 1'b1;
            if (req_write) begin
              // Gate stays high so the lanes never fight
              nxt_s.st       = bsr_pkg::BSR_WR;
              nxt_s.strobe_n = 1'b0;
              nxt_s.oe_n     = 1'b0;
              nxt_s.cnt      = bsr_pkg::CNT_STROBE;
            end else begin
              nxt_s.st     = bsr_pkg::BSR_RD;
              nxt_s.gate_n = 1'b0;
              nxt_s.cnt    = bsr_pkg::CNT_ACCESS;
            end
          end
        end
        bsr_pkg::BSR_RD: begin
          // Sample only after access time plus sync delay; earlier is garbage
          if (s_ff.cnt == bsr_pkg::CNT_ZERO) begin
            nxt_s.rdata  = lanes_q;
            nxt_s.rsp    = 1'b1;
            nxt_s.gate_n = 1'b1;
            nxt_s.sel_n  = 1'b1;
            nxt_s.sel_h  = 1'b0;
            nxt_s.st     = bsr_pkg::BSR_RECOV;
            nxt_s.cnt    = bsr_pkg::CNT_FLOAT;
          end
        end
        bsr_pkg::BSR_WR: begin
          if (s_ff.cnt == bsr_pkg::CNT_ZERO) begin
            // Strobe and select_low_n rise as select_high falls, all together; data held one more cycle for hold time
            nxt_s.strobe_n = 1'b1;
            nxt_s.sel_n    = 1'b1;
            nxt_s.sel_h    = 1'b0;
            nxt_s.rsp      = 1'b1;
            nxt_s.st       = bsr_pkg::BSR_RECOV;
            nxt_s.cnt      = bsr_pkg::CNT_RECOVER;
          end
        end
        bsr_pkg::BSR_RECOV: begin
          nxt_s.oe_n = 1'b1;
          if (s_ff.cnt == bsr_pkg::CNT_ZERO) begin
            nxt_s.st    = bsr_pkg::BSR_IDLE;
            nxt_s.ready = 1'b1;
          end
        end
        bsr_pkg::BSR_FAILED: begin
          // Stay deselected until both supply and interrupt are clean
          if (!fail_now) begin
            nxt_s.fail  = 1'b0;
            nxt_s.st    = bsr_pkg::BSR_RECOV;
            nxt_s.cnt   = bsr_pkg::CNT_FLOAT;
          end
        end
        default: begin
          nxt_s.st = bsr_pkg::BSR_FAILED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_ff          <= '0;
      s_ff.st       <= bsr_pkg::BSR_FAILED;
      s_ff.addr     <= bsr_pkg::ADDR_RST;
      s_ff.wdata    <= bsr_pkg::DATA_RST;
      s_ff.sel_n    <= 1'b1;
      s_ff.gate_n   <= 1'b1;
      s_ff.strobe_n <= 1'b1;
      s_ff.oe_n     <= 1'b1;
      s_ff.fail     <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign req_ready       = s_ff.ready;
  assign rsp_valid       = s_ff.rsp;
  assign rsp_rdata       = s_ff.rdata;
  assign power_fail      = s_ff.fail;
  assign location_select = s_ff.addr;
  assign select_low_n    = s_ff.sel_n;
  assign select_high     = s_ff.sel_h;
  assign gate_n          = s_ff.gate_n;
  assign strobe_n        = s_ff.strobe_n;
  assign byte_lanes_o    = s_ff.wdata;
  assign byte_lanes_oe_n = s_ff.oe_n;
endmodule

module bsr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] raw,
  output logic [W-1:0]      synced
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] hold;
  } bsr_sync_regs_t;

  bsr_sync_regs_t s_ff;
  bsr_sync_regs_t nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.meta = raw;
    // Only the second stage leaves this module
    nxt_s.hold = s_ff.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Zero reads as supply bad, so the host starts deselected
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign synced = s_ff.hold;
endmodule

/* design/bsr_pkg.sv */
package bsr_pkg;
  localparam int CLK_HZ           = 10000000;
  localparam int ADDR_W           = 13;
  localparam int DATA_W           = 8;
  // Timing figures in ns, slowest speed grade
  localparam int T_CYCLE_NS       = 150;
  localparam int T_ACCESS_NS      = 150;
  localparam int T_STROBE_NS      = 130;
  localparam int T_DATA_SETUP_NS  = 70;
  localparam int T_RECOVER_NS     = 10;
  localparam int T_FLOAT_NS       = 75;
  // Least times round up
  localparam int CYC_ACCESS  = (T_ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000 + 1;
  localparam int CYC_STROBE  = (T_STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CYC_RECOVER = (T_RECOVER_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CYC_FLOAT   = (T_FLOAT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W       = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ACCESS  = CNT_W'(CYC_ACCESS);
  localparam logic [CNT_W-1:0] CNT_STROBE  = CNT_W'(CYC_STROBE);
  localparam logic [CNT_W-1:0] CNT_RECOVER = CNT_W'(CYC_RECOVER);
  localparam logic [CNT_W-1:0] CNT_FLOAT   = CNT_W'(CYC_FLOAT);
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    BSR_IDLE   = 3'h0,
    BSR_RD     = 3'h1,
    BSR_WR     = 3'h2,
    BSR_RECOV  = 3'h3,
    BSR_FAILED = 3'h4
  } bsr_state_t;
endpackage
